// ---- rtl/lbc_top.v ----
// led bank control logic: holding registers, load on stop, bank enables, pump mode
// assumes synchronous pin inputs, serial lines sampled on MCLK_IN
// What this block does
// (R1) two 4-bit camera settings, pin or port
// (R2) level pin high selects high camera setting
// (R3) level pin falling edge resets pump to 1x
// (R4) camera code zero disables camera outputs
// (R5) aux own code or follows cam/sub/main
// (R6) fourth aux usable as logic output
// (R7) both aux fields zero disable aux
// (R8) supply undervoltage holds all setting registers zero
// (R9) main 8-bit code, zero disables
// (R10) sub 8-bit code, zero disables
// (R11) three independent 4-bit color codes
// (R12) color outputs usable as logic outputs
// (R13) zero color field disables that color
// (R14) enable pin gates color or sub group
// (R15) enable pin rise restores retained settings
// (R16) host shifts one bit per clock
// (R17) msb first, sampled on rising clock
// (R18) stop loads holding into active registers
// (R19) any data write resets pump to 1x
// (R20) all settings zero means shutdown
// (R21) pump steps 1x, 1.5x, 2x on dropout
`include "lbc_regs.vh"
module lbc_top #(
  parameter [6:0] DEV_ADDR = `LBC_ADDR_DEFAULT
) (
  input wire MCLK_IN,
  input wire RESET_IN,
  input wire UVLO_IN,
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OE_OUT,
  input wire CAM_LEVEL_IN,
  input wire COLOR_SUB_EN_IN,
  input wire DROPOUT_IN,
  output reg [7:0] MAIN_CODE_OUT,
  output reg MAIN_EN_OUT,
  output reg [7:0] SUB_CODE_OUT,
  output reg SUB_EN_OUT,
  output reg [3:0] CAM_CODE_OUT,
  output reg CAM_EN_OUT,
  output reg [3:0] RED_CODE_OUT,
  output reg [3:0] GREEN_CODE_OUT,
  output reg [3:0] BLUE_CODE_OUT,
  output reg [2:0] RGB_EN_OUT,
  output reg [2:0] RGB_LOGIC_LOW_OUT,
  output reg [15:0] AUX_CODE_OUT,
  output reg [3:0] AUX_EN_OUT,
  output reg AUX4_LOGIC_LOW_OUT,
  output reg [2:0] PUMP_MODE_OUT,
  output reg SHUTDOWN_OUT
);
  wire rst = RESET_IN | UVLO_IN; // undervoltage clears everything [R8]
  wire rx_sda_low;
  wire wr_stb;
  wire [2:0] wr_sub;
  wire [7:0] wr_data;
  wire stop_stb;
  lbc_rx #(.DEV_ADDR(DEV_ADDR)) u_rx (
    .clk(MCLK_IN),
    .rst(rst),
    .scl(SCL_IN),
    .sda(SDA_IN),
    .sda_low(rx_sda_low),
    .wr_stb(wr_stb),
    .wr_sub(wr_sub),
    .wr_data(wr_data),
    .stop_stb(stop_stb)
  );
  // holding registers written by the port [R16]
  reg [7:0] h_main, h_sub, h_rg, h_baux, h_aux, h_cam, h_cfg;
  // active registers loaded at stop
  reg [7:0] a_main, a_sub, a_rg, a_baux, a_aux, a_cam, a_cfg;
  reg cam_lvl_d;
  reg dropout_d;
  always @(posedge MCLK_IN) begin
    if (rst) begin
      h_main <= 8'h00; h_sub <= 8'h00; h_rg <= 8'h00; h_baux <= 8'h00;
      h_aux <= 8'h00; h_cam <= 8'h00; h_cfg <= 8'h00;
      a_main <= 8'h00; a_sub <= 8'h00; a_rg <= 8'h00; a_baux <= 8'h00;
      a_aux <= 8'h00; a_cam <= 8'h00; a_cfg <= 8'h00;
    end else begin
      if (wr_stb) begin
        case (wr_sub)
          `LBC_SUB_MAIN: h_main <= wr_data;
          `LBC_SUB_SUB: h_sub <= wr_data;
          `LBC_SUB_RG: h_rg <= wr_data;
          `LBC_SUB_BAUX: h_baux <= wr_data;
          `LBC_SUB_AUX: h_aux <= wr_data;
          `LBC_SUB_CAM: h_cam <= wr_data;
          `LBC_SUB_CFG: h_cfg <= wr_data;
          default: h_main <= h_main;
        endcase
      end
      if (stop_stb) begin // copy all at once after stop [R18]
        a_main <= h_main; a_sub <= h_sub; a_rg <= h_rg; a_baux <= h_baux;
        a_aux <= h_aux; a_cam <= h_cam; a_cfg <= h_cfg;
      end
    end
  end
  // camera: high nibble high setting, low nibble low setting [R1]
  wire cam_hi_sel = a_cfg[`LBC_CFG_CAM_BY_PORT] ? a_cfg[`LBC_CFG_CAM_PORT_HIGH] :
    CAM_LEVEL_IN; // [R2]
  wire [3:0] cam_code = cam_hi_sel ? a_cam[7:4] : a_cam[3:0];
  wire [3:0] red_f = a_rg[7:4];
  wire [3:0] green_f = a_rg[3:0];
  wire [3:0] blue_f = a_baux[7:4];
  // baux low nibble: two select bits for aux outputs 1,2; aux reg high nibble
  // holds selects for 3,4, low nibble the aux dac code
  wire [7:0] aux_sel = {a_aux[7:4], a_baux[3:0]};
  wire [3:0] aux_dac = a_aux[3:0];
  wire en_sub_grp = a_cfg[`LBC_CFG_ENPIN_SUB];
  // pin low blanks the chosen group; settings stay in place [R14] [R15]
  wire sub_gate = ~en_sub_grp | COLOR_SUB_EN_IN;
  wire rgb_gate = en_sub_grp | COLOR_SUB_EN_IN;
  wire main_on = a_main != `LBC_BYTE_ZERO; // [R9]
  wire sub_on = a_sub != `LBC_BYTE_ZERO; // [R10]
  wire cam_on = cam_code != `LBC_NIB_ZERO; // [R4]
  wire aux_all_off = (a_aux == `LBC_BYTE_ZERO) && (a_baux[3:0] == `LBC_NIB_ZERO); // [R7]
  reg [15:0] next_aux_code;
  reg [3:0] next_aux_en;
  integer i;
  always @* begin
    next_aux_code = 16'h0000;
    next_aux_en = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      case (aux_sel[2*i +: 2]) // per-output source choice [R5]
        `LBC_SEL_MAIN: begin
          next_aux_code[4*i +: 4] = a_main[7:4];
          next_aux_en[i] = main_on;
        end
        `LBC_SEL_SUB: begin
          next_aux_code[4*i +: 4] = a_sub[7:4];
          next_aux_en[i] = sub_on & sub_gate;
        end
        `LBC_SEL_CAM: begin
          next_aux_code[4*i +: 4] = cam_code;
          next_aux_en[i] = cam_on;
        end
        default: begin
          next_aux_code[4*i +: 4] = aux_dac;
          next_aux_en[i] = aux_dac != `LBC_NIB_ZERO;
        end
      endcase
    end
    if (aux_all_off) begin
      next_aux_en = 4'h0; // [R7]
    end
    if (a_cfg[`LBC_CFG_AUX4_LOGIC]) begin
      next_aux_en[3] = 1'b0; // aux4 taken as logic output [R6]
    end
  end
  wire all_zero = (a_main | a_sub | a_rg | a_baux | a_aux | a_cam) == `LBC_BYTE_ZERO;
  wire [2:0] col_nz = {blue_f != `LBC_NIB_ZERO, green_f != `LBC_NIB_ZERO,
    red_f != `LBC_NIB_ZERO};
  wire rgb_logic = a_cfg[`LBC_CFG_RGB_LOGIC];
  always @(posedge MCLK_IN) begin
    if (rst) begin
      SDA_OE_OUT <= 1'b0;
      MAIN_CODE_OUT <= 8'h00; MAIN_EN_OUT <= 1'b0;
      SUB_CODE_OUT <= 8'h00; SUB_EN_OUT <= 1'b0;
      CAM_CODE_OUT <= 4'h0; CAM_EN_OUT <= 1'b0;
      RED_CODE_OUT <= 4'h0; GREEN_CODE_OUT <= 4'h0; BLUE_CODE_OUT <= 4'h0;
      RGB_EN_OUT <= 3'h0; RGB_LOGIC_LOW_OUT <= 3'h0;
      AUX_CODE_OUT <= 16'h0000; AUX_EN_OUT <= 4'h0; AUX4_LOGIC_LOW_OUT <= 1'b0;
      SHUTDOWN_OUT <= 1'b1;
    end else begin
      SDA_OE_OUT <= rx_sda_low;
      MAIN_CODE_OUT <= a_main;
      MAIN_EN_OUT <= main_on; // [R9]
      SUB_CODE_OUT <= a_sub;
      SUB_EN_OUT <= sub_on & sub_gate; // [R10] [R14]
      CAM_CODE_OUT <= cam_code; // [R2]
      CAM_EN_OUT <= cam_on; // [R4]
      RED_CODE_OUT <= red_f; // [R11]
      GREEN_CODE_OUT <= green_f;
      BLUE_CODE_OUT <= blue_f;
      RGB_EN_OUT <= rgb_logic ? 3'h0 : (col_nz & {3{rgb_gate}}); // [R13] [R14]
      RGB_LOGIC_LOW_OUT <= rgb_logic ? a_cfg[`LBC_CFG_RGB_LEVEL_LSB +: 2] == 2'h0 ?
        3'h0 : {a_cfg[7], a_cfg[7:6]} : 3'h0; // [R12]
      AUX_CODE_OUT <= next_aux_code;
      AUX_EN_OUT <= next_aux_en;
      AUX4_LOGIC_LOW_OUT <= a_cfg[`LBC_CFG_AUX4_LOGIC] & a_cfg[`LBC_CFG_AUX4_LEVEL]; // [R6]
      SHUTDOWN_OUT <= all_zero; // [R20]
    end
  end
  // pump mode state machine
  wire any_enabled = |{MAIN_EN_OUT, SUB_EN_OUT, CAM_EN_OUT, RGB_EN_OUT, AUX_EN_OUT};
  wire drop_evt = DROPOUT_IN & ~dropout_d & any_enabled;
  wire cam_fall = cam_lvl_d & ~CAM_LEVEL_IN;
  reg [2:0] next_pump;
  always @* begin
    case (PUMP_MODE_OUT)
      `LBC_PUMP_1X: next_pump = drop_evt ? `LBC_PUMP_1P5X : `LBC_PUMP_1X;
      `LBC_PUMP_1P5X: next_pump = drop_evt ? `LBC_PUMP_2X : `LBC_PUMP_1P5X;
      `LBC_PUMP_2X: next_pump = `LBC_PUMP_2X; // [R21]
      default: next_pump = `LBC_PUMP_1X;
    endcase
    if (cam_fall) begin
      next_pump = `LBC_PUMP_1X; // [R3]
    end
    if (wr_stb) begin
      next_pump = `LBC_PUMP_1X; // [R19]
    end
  end
  always @(posedge MCLK_IN) begin
    if (rst) begin
      cam_lvl_d <= 1'b0;
      dropout_d <= 1'b0;
      PUMP_MODE_OUT <= `LBC_PUMP_1X;
    end else begin
      cam_lvl_d <= CAM_LEVEL_IN;
      dropout_d <= DROPOUT_IN;
      PUMP_MODE_OUT <= next_pump;
    end
  end
endmodule

// ---- rtl/lbc_regs.vh ----
// constants for the led bank control logic: field widths, codes, pump states
// assumes inclusion by lbc_top.v, lbc_rx.v and the bench
`ifndef LBC_REGS_VH
`define LBC_REGS_VH
`define LBC_ADDR_DEFAULT 7'h1b
`define LBC_SUB_MAIN 3'h1
`define LBC_SUB_SUB 3'h2
`define LBC_SUB_RG 3'h3
`define LBC_SUB_BAUX 3'h4
`define LBC_SUB_AUX 3'h5
`define LBC_SUB_CAM 3'h6
`define LBC_SUB_CFG 3'h7
`define LBC_SEL_AUXDAC 2'h0
`define LBC_SEL_MAIN 2'h1
`define LBC_SEL_SUB 2'h2
`define LBC_SEL_CAM 2'h3
`define LBC_CFG_CAM_BY_PORT 0
`define LBC_CFG_ENPIN_SUB 1
`define LBC_CFG_CAM_PORT_HIGH 2
`define LBC_CFG_AUX4_LOGIC 3
`define LBC_CFG_AUX4_LEVEL 4
`define LBC_CFG_RGB_LOGIC 5
`define LBC_CFG_RGB_LEVEL_LSB 6
`define LBC_PUMP_1X 3'h1
`define LBC_PUMP_1P5X 3'h2
`define LBC_PUMP_2X 3'h4
`define LBC_BYTE_ZERO 8'h00
`define LBC_NIB_ZERO 4'h0
`define LBC_BYTE_BITS 4'h8
`endif

// ---- rtl/lbc_rx.v ----
// serial receiver: address byte, sub-address byte, data byte per write
// assumes scl/sda synchronous samples of the two-wire lines, open-drain sda ack
`include "lbc_regs.vh"
module lbc_rx #(
  parameter [6:0] DEV_ADDR = `LBC_ADDR_DEFAULT
) (
  input wire clk,
  input wire rst,
  input wire scl,
  input wire sda,
  output reg sda_low,
  output reg wr_stb,
  output reg [2:0] wr_sub,
  output reg [7:0] wr_data,
  output reg stop_stb
);
  reg scl_d;
  reg sda_d;
  reg active;
  reg [3:0] bitcnt;
  reg [7:0] shift;
  reg [1:0] phase;
  reg in_ack;
  reg dirty;
  wire rise = scl & ~scl_d;
  wire fall = ~scl & scl_d;
  wire start = scl & scl_d & sda_d & ~sda;
  wire stop = scl & scl_d & ~sda_d & sda;
  always @(posedge clk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      active <= 1'b0;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      phase <= 2'h0;
      in_ack <= 1'b0;
      sda_low <= 1'b0;
      wr_stb <= 1'b0;
      wr_sub <= 3'h0;
      wr_data <= 8'h00;
      stop_stb <= 1'b0;
      dirty <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      wr_stb <= 1'b0;
      stop_stb <= 1'b0;
      if (start) begin
        active <= 1'b1;
        bitcnt <= 4'h0;
        phase <= 2'h0;
        in_ack <= 1'b0;
        sda_low <= 1'b0;
      end else if (stop) begin
        active <= 1'b0;
        sda_low <= 1'b0;
        stop_stb <= dirty;
        dirty <= 1'b0;
      end else if (active && rise && !in_ack) begin
        shift <= {shift[6:0], sda}; // msb first, sampled on rising clock [R17]
        bitcnt <= bitcnt + 4'h1;
      end else if (active && fall) begin
        if (in_ack) begin
          in_ack <= 1'b0;
          sda_low <= 1'b0;
        end else if (bitcnt == `LBC_BYTE_BITS) begin
          bitcnt <= 4'h0;
          if (phase == 2'h0) begin
            if (shift[7:1] == DEV_ADDR && !shift[0]) begin
              phase <= 2'h1;
              in_ack <= 1'b1;
              sda_low <= 1'b1;
            end else begin
              active <= 1'b0;
            end
          end else if (phase == 2'h1) begin
            wr_sub <= shift[2:0];
            phase <= 2'h2;
            in_ack <= 1'b1;
            sda_low <= 1'b1;
          end else begin
            wr_data <= shift;
            wr_stb <= 1'b1;
            dirty <= 1'b1;
            phase <= 2'h1;
            in_ack <= 1'b1;
            sda_low <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ---- tb/lbc_chk.sv ----
// checker: port-level relations of the led bank control logic
// assumes bind onto lbc_top, one clock, sync active-high reset
module lbc_chk (
  input wire MCLK_IN,
  input wire RESET_IN,
  input wire UVLO_IN,
  input wire CAM_LEVEL_IN,
  input wire COLOR_SUB_EN_IN,
  input wire [7:0] MAIN_CODE_OUT,
  input wire MAIN_EN_OUT,
  input wire [7:0] SUB_CODE_OUT,
  input wire SUB_EN_OUT,
  input wire [3:0] CAM_CODE_OUT,
  input wire CAM_EN_OUT,
  input wire [3:0] RED_CODE_OUT,
  input wire [2:0] RGB_EN_OUT,
  input wire [2:0] PUMP_MODE_OUT,
  input wire SHUTDOWN_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);
  sequence en_pin_low;
    !COLOR_SUB_EN_IN [*4];
  endsequence
  uvlo_clear_a: assert property (UVLO_IN |=> MAIN_CODE_OUT == 8'h00 && SUB_CODE_OUT == 8'h00
    && SHUTDOWN_OUT) else $error("undervoltage did not clear settings");
  main_zero_a: assert property (MAIN_EN_OUT |-> MAIN_CODE_OUT != 8'h00)
    else $error("main enabled with zero code");
  sub_zero_a: assert property (SUB_EN_OUT |-> SUB_CODE_OUT != 8'h00)
    else $error("sub enabled with zero code");
  cam_zero_a: assert property (CAM_EN_OUT |-> CAM_CODE_OUT != 4'h0)
    else $error("camera enabled with zero code");
  red_zero_a: assert property (RGB_EN_OUT[0] |-> RED_CODE_OUT != 4'h0)
    else $error("red enabled with zero code");
  pump_onehot_a: assert property ($onehot(PUMP_MODE_OUT))
    else $error("pump mode not one-hot");
  pump_step_a: assert property (PUMP_MODE_OUT == 3'h1 |=> PUMP_MODE_OUT != 3'h4)
    else $error("pump skipped a step");
  cam_fall_a: assert property ($fell(CAM_LEVEL_IN) |-> ##[1:3] PUMP_MODE_OUT == 3'h1)
    else $error("level fall did not reset pump");
  shut_down_a: assert property (SHUTDOWN_OUT |-> !MAIN_EN_OUT && !SUB_EN_OUT && !CAM_EN_OUT)
    else $error("bank enabled during shutdown");
  en_gate_a: assert property (en_pin_low |-> RGB_EN_OUT == 3'h0 || !SUB_EN_OUT)
    else $error("enable pin low gated no group");
endmodule
bind lbc_top lbc_chk lbc_chk_i (.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .UVLO_IN(UVLO_IN),
  .CAM_LEVEL_IN(CAM_LEVEL_IN), .COLOR_SUB_EN_IN(COLOR_SUB_EN_IN),
  .MAIN_CODE_OUT(MAIN_CODE_OUT), .MAIN_EN_OUT(MAIN_EN_OUT), .SUB_CODE_OUT(SUB_CODE_OUT),
  .SUB_EN_OUT(SUB_EN_OUT), .CAM_CODE_OUT(CAM_CODE_OUT), .CAM_EN_OUT(CAM_EN_OUT),
  .RED_CODE_OUT(RED_CODE_OUT), .RGB_EN_OUT(RGB_EN_OUT), .PUMP_MODE_OUT(PUMP_MODE_OUT),
  .SHUTDOWN_OUT(SHUTDOWN_OUT));

// ---- tb/lbc_host.sv ----
// two-wire host model: start, address, sub-address, data, stop
// assumes the bench resolves the pulled-up data line from both drivers
module lbc_host (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ack_ok;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      half;
      scl = 1'b1;
      half;
      scl = 1'b0;
    end
    sda_low = 1'b0;
    half;
    scl = 1'b1;
    half;
    ack_ok = (sda_in === 1'b0);
    scl = 1'b0;
  endtask
  task automatic write(input logic [6:0] a, input logic [2:0] sub, input logic [7:0] d,
                       output logic ok);
    sda_low = 1'b0;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b1;
    half;
    scl = 1'b0;
    send({a, 1'b0});
    ok = ack_ok;
    send({5'h00, sub});
    send(d);
    ok = ok & ack_ok;
    sda_low = 1'b1;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b0;
    half;
  endtask
endmodule

// ---- tb/testbench.sv ----
// bench: programs the block through the host model and checks the bank outputs
// assumes 25 MHz clock, pull-up on the data line
`include "lbc_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, uvlo = 0, cam_lvl = 0, en_pin = 1, drop = 0, ok;
  wire scl, host_low, sda_oe, main_en, sub_en, cam_en, aux4_low, shdn;
  wire sda = !(host_low || sda_oe);
  wire [7:0] main_c, sub_c;
  wire [3:0] cam_c, red_c, grn_c, blu_c, aux_en;
  wire [2:0] rgb_en, rgb_low, pump;
  wire [15:0] aux_c;
  int err_total = 0, total_checks = 0, cyc = 0;
  always #20 mclk = !mclk;
  lbc_top lbc_top_i (.MCLK_IN(mclk), .RESET_IN(rst), .UVLO_IN(uvlo), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OE_OUT(sda_oe), .CAM_LEVEL_IN(cam_lvl), .COLOR_SUB_EN_IN(en_pin), .DROPOUT_IN(drop),
    .MAIN_CODE_OUT(main_c), .MAIN_EN_OUT(main_en), .SUB_CODE_OUT(sub_c), .SUB_EN_OUT(sub_en),
    .CAM_CODE_OUT(cam_c), .CAM_EN_OUT(cam_en), .RED_CODE_OUT(red_c), .GREEN_CODE_OUT(grn_c),
    .BLUE_CODE_OUT(blu_c), .RGB_EN_OUT(rgb_en), .RGB_LOGIC_LOW_OUT(rgb_low),
    .AUX_CODE_OUT(aux_c), .AUX_EN_OUT(aux_en), .AUX4_LOGIC_LOW_OUT(aux4_low),
    .PUMP_MODE_OUT(pump), .SHUTDOWN_OUT(shdn));
  lbc_host lbc_host_i (.clk(mclk), .sda_in(sda), .scl(scl), .sda_low(host_low));
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [2:0] sub, input logic [7:0] d);
    lbc_host_i.write(`LBC_ADDR_DEFAULT, sub, d, ok);
    step(4);
    chk("ack", 1, ok);
  endtask
  task automatic pulse;
    drop = 1;
    step(2);
    drop = 0;
    step(3);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      results;
    end
  end
  initial begin
    step(10);
    rst = 0;
    step(2);
    chk("pump", `LBC_PUMP_1X, pump);
    chk("shdn", 1, shdn);
    lbc_host_i.write(7'h1c, 3'h1, 8'h11, ok);
    step(4);
    chk("nak", 0, {ok, main_c});
    wr(3'h1, 8'h80);
    chk("main", 16'h8001, {main_c, 7'h00, main_en});
    chk("shdn", 0, shdn);
    wr(3'h2, 8'h01);
    chk("sub", 16'h0101, {sub_c, 7'h00, sub_en});
    wr(3'h3, 8'h5a);
    wr(3'h4, 8'h30);
    chk("rgb", 16'h5a37, {red_c, grn_c, blu_c, 1'b0, rgb_en});
    wr(3'h3, 8'h0a);
    chk("rgb_en", 3'h6, rgb_en);
    en_pin = 0;
    step(4);
    chk("gate_rgb", 4'h1, {rgb_en, sub_en});
    en_pin = 1;
    step(4);
    chk("back_rgb", 4'hd, {rgb_en, sub_en});
    wr(3'h7, 8'h02);
    en_pin = 0;
    step(4);
    chk("gate_sub", 4'hc, {rgb_en, sub_en});
    en_pin = 1;
    step(4);
    chk("back_sub", 4'hd, {rgb_en, sub_en});
    wr(3'h6, 8'h9c);
    cam_lvl = 1;
    step(4);
    chk("cam_hi", 5'h13, {cam_c, cam_en});
    cam_lvl = 0;
    step(4);
    chk("cam_lo", 5'h19, {cam_c, cam_en});
    wr(3'h7, 8'h05);
    chk("cam_port", 5'h13, {cam_c, cam_en});
    wr(3'h6, 8'h00);
    chk("cam_off", 0, cam_en);
    wr(3'h4, 8'h35);
    wr(3'h5, 8'h07);
    chk("aux", 16'h7788, aux_c);
    chk("aux_en", 4'hf, aux_en);
    // aux1 follows sub, aux2 follows camera, aux3 and aux4 keep own code
    wr(3'h2, 8'hb1);
    wr(3'h6, 8'h9c);
    wr(3'h4, 8'h3e);
    chk("aux_follow", 16'h779b, aux_c);
    chk("aux_follow_en", 4'hf, aux_en);
    wr(3'h4, 8'h30);
    wr(3'h5, 8'h00);
    chk("aux_off", 0, aux_en);
    wr(3'h7, 8'hb8);
    chk("logic", 4'hd, {rgb_low, aux4_low});
    pulse;
    chk("pump", `LBC_PUMP_1P5X, pump);
    pulse;
    pulse;
    chk("pump", `LBC_PUMP_2X, pump);
    wr(3'h1, 8'h40);
    chk("pump", `LBC_PUMP_1X, pump);
    pulse;
    chk("pump", `LBC_PUMP_1P5X, pump);
    cam_lvl = 1;
    step(4);
    cam_lvl = 0;
    step(4);
    chk("pump", `LBC_PUMP_1X, pump);
    uvlo = 1;
    step(2);
    uvlo = 0;
    step(1);
    chk("uvlo", 16'h0001, {main_c, sub_c[7:1], shdn});
    results;
  end
endmodule
